// ==== common/ttr_pkg.sv ====
package ttr_pkg;
  // special-function-register addresses
  localparam logic [7:0] TTR_ADDR_RATE   = 8'h8e;
  localparam logic [7:0] TTR_ADDR_CTRL   = 8'hc8;
  localparam logic [7:0] TTR_ADDR_RCAP_L = 8'hca;
  localparam logic [7:0] TTR_ADDR_RCAP_H = 8'hcb;
  localparam logic [7:0] TTR_ADDR_CNT_L  = 8'hcc;
  localparam logic [7:0] TTR_ADDR_CNT_H  = 8'hcd;

  // timer_rate_select field positions
  localparam int TTR_RATE_T2_BIT = 5;
  localparam int TTR_RATE_T1_BIT = 4;
  localparam int TTR_RATE_T0_BIT = 3;
  localparam logic [7:0] TTR_RATE_WMASK = 8'h38;

  // timer_two_control field positions
  localparam int TTR_CTL_OVF_BIT  = 7;
  localparam int TTR_CTL_EXF_BIT  = 6;
  localparam int TTR_CTL_RXB_BIT  = 5;
  localparam int TTR_CTL_TXB_BIT  = 4;
  localparam int TTR_CTL_EXEN_BIT = 3;
  localparam int TTR_CTL_RUN_BIT  = 2;
  localparam int TTR_CTL_CT_BIT   = 1;
  localparam int TTR_CTL_CPRL_BIT = 0;

  // values after reset, and the top count value before rollover
  localparam logic [7:0]  TTR_RATE_RST = 8'h00;
  localparam logic [7:0]  TTR_CTL_RST  = 8'h00;
  localparam logic [15:0] TTR_WORD_RST = 16'h0000;
  localparam logic [15:0] TTR_CNT_MAX  = 16'hffff;

  // clock rates: 200 MHz system clock, time base in clk periods
  localparam int TTR_CLK_MHZ      = 200;
  localparam int TTR_SLOW_CYCLES  = 12;
  localparam int TTR_FAST_CYCLES  = 4;
  localparam int TTR_BAUD_CYCLES  = 2;
  localparam logic [3:0] TTR_SLOW_LAST = 4'(TTR_SLOW_CYCLES - 1);
  localparam logic [3:0] TTR_FAST_LAST = 4'(TTR_FAST_CYCLES - 1);
  localparam logic [3:0] TTR_BAUD_LAST = 4'(TTR_BAUD_CYCLES - 1);

  typedef enum logic [1:0] {
    TTR_MODE_OFF,
    TTR_MODE_CAPTURE,
    TTR_MODE_RELOAD,
    TTR_MODE_BAUD
  } ttr_mode_t;

  // register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ttr_sfr_req_t;

  // complete state of the timer block
  typedef struct packed {
    logic [7:0]  rate;
    logic [7:0]  ctrl;
    logic [15:0] rcap;
    logic [15:0] cnt;
    logic [3:0]  pre_t2;
    logic [3:0]  pre_t1;
    logic [3:0]  pre_t0;
    logic [2:0]  tick;
    logic [1:0]  cnt_pin_sync;
    logic        cnt_pin_prev;
    logic [1:0]  ext_pin_sync;
    logic        ext_pin_prev;
    logic [7:0]  rdata;
    logic        ovf_pulse;
    logic        rx_baud_pulse;
    logic        tx_baud_pulse;
    logic        irq;
  } ttr_state_t;
endpackage

// ==== src/ttr_timer_two.sv ====
`timescale 1ns/1ps
// Function
// - fast select 1 gives one step per 4 clk, 0 gives per 12
// - fast selects reset to 0; the timer 2 select (bit5) does nothing when counting pin edges
// - rate register: bit5 timer 2, bit4 timer 1, bit3 timer 0; baud ignores bit5
// - timer exists only with build parameter 1; always one 16-bit count
// - rollover from ffff sets overflow flag only when both baud selects are 0
// - software writing 1 to either flag raises interrupt request if enabled
// - capture or reload from trigger pin edge sets external flag when enabled
// - rx and tx baud selects route this overflow to serial port 0 clocks
// - trigger pin falling edge captures or reloads only if enabled and not baud mode
// - run control 1 counts, 0 stops the timer regardless of other bits
// - counter select 0 counts divided clk, 1 counts count pin falling edges
// - baud timer function steps every 2 clk; other modes use 4 or 12
// - capture select 1 captures, 0 reloads; baud forces reload on overflow
// - mode decode: capture, auto-reload, baud generator, or off
// - rollover in timer/counter modes sets flag and pulses output one clk
// - capture mode edge copies count bytes into reload/capture registers
// - auto-reload overflow sets flag and loads count from reload registers
// - auto-reload edge with trigger enabled forces immediate reload
// - baud overflow reloads and emits shift pulse instead of setting flag
// - in baud mode hardware sets only the external flag; a software-set overflow flag still requests the interrupt
// - baud time base is clk/2, or count pin edges when counter select 1
module ttr_timer_two
  import ttr_pkg::*;
#(
  parameter bit TIMER2_PRESENT = 1'b1
)
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       count_input_pin,
  input  wire logic       ext_capture_reload_pin,
  input  wire logic       timer2_irq_enable,
  output logic            overflow_pulse_out,
  output logic            rx_baud_clk_pulse,
  output logic            tx_baud_clk_pulse,
  output logic            timer2_irq,
  output logic            timer1_tick,
  output logic            timer0_tick
);

  ttr_state_t   st_reg;
  ttr_state_t   st_next;
  ttr_sfr_req_t req;

  // true when this address belongs to the timer 2 block
  function automatic logic t2_addr(input logic [7:0] a);
    case (a)
      TTR_ADDR_CTRL, TTR_ADDR_RCAP_L, TTR_ADDR_RCAP_H, TTR_ADDR_CNT_L, TTR_ADDR_CNT_H:
      begin
        t2_addr = 1'b1;
      end
      default:
      begin
        t2_addr = 1'b0;
      end
    endcase
  endfunction

  // advances a prescaler and reports the last cycle of its period
  function automatic logic [4:0] prescale(input logic [3:0] cur, input logic fast);
    logic [3:0] last;
    last = fast ? TTR_FAST_LAST : TTR_SLOW_LAST;
    if (cur >= last)
    begin
      prescale = {4'h0, 1'b1};
    end
    else
    begin
      prescale = {4'(cur + 4'h1), 1'b0};
    end
  endfunction

  // falling edge between the older and the newer synchronised sample
  function automatic logic fell(input logic older, input logic newer);
    fell = older & ~newer;
  endfunction

  // mode decode; a stopped timer ignores every other control bit
  function automatic ttr_mode_t mode_of(input logic [7:0] ctrl);
    if (!ctrl[TTR_CTL_RUN_BIT])
    begin
      mode_of = TTR_MODE_OFF;
    end
    else if (ctrl[TTR_CTL_RXB_BIT] || ctrl[TTR_CTL_TXB_BIT])
    begin
      mode_of = TTR_MODE_BAUD;
    end
    else if (ctrl[TTR_CTL_CPRL_BIT])
    begin
      mode_of = TTR_MODE_CAPTURE;
    end
    else
    begin
      mode_of = TTR_MODE_RELOAD;
    end
  endfunction

  // read multiplexer; reserved rate bits come back zero because they are never stored
  function automatic logic [7:0] read_mux(input logic [7:0] a, input ttr_state_t s);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      TTR_ADDR_RATE:
        d = s.rate;
      TTR_ADDR_CTRL:
        d = s.ctrl;
      TTR_ADDR_RCAP_L:
        d = s.rcap[7:0];
      TTR_ADDR_RCAP_H:
        d = s.rcap[15:8];
      TTR_ADDR_CNT_L:
        d = s.cnt[7:0];
      TTR_ADDR_CNT_H:
        d = s.cnt[15:8];
      default:
        d = 8'h00;
    endcase
    if (!TIMER2_PRESENT && t2_addr(a))
    begin
      d = 8'h00;
    end
    read_mux = d;
  endfunction

  assign req.wr    = sfr_wr;
  assign req.rd    = sfr_rd;
  assign req.addr  = sfr_addr;
  assign req.wdata = sfr_wdata;

  logic       run;
  logic       baud;
  logic       ct_sel;
  logic       ex_en;
  ttr_mode_t  mode;
  logic       cnt_edge;
  logic       ext_edge;
  logic       step;
  logic       rolls;
  logic       trig;
  logic [4:0] ps2;
  logic [4:0] ps1;
  logic [4:0] ps0;
  logic [3:0] baud_ps;
  logic       baud_tick;
  logic       cap_now;
  logic       ovf_set;
  logic       exf_set;
  logic [15:0] cnt_step;

  always_comb
  begin
    st_next = st_reg;

    run    = st_reg.ctrl[TTR_CTL_RUN_BIT];
    baud   = st_reg.ctrl[TTR_CTL_RXB_BIT] | st_reg.ctrl[TTR_CTL_TXB_BIT];
    ct_sel = st_reg.ctrl[TTR_CTL_CT_BIT];
    ex_en  = st_reg.ctrl[TTR_CTL_EXEN_BIT];

    // run control dominates the mode decode
    mode = mode_of(st_reg.ctrl);

    // pin synchronisers; only the second stage and later are looked at
    st_next.cnt_pin_sync = {st_reg.cnt_pin_sync[0], count_input_pin};
    st_next.cnt_pin_prev = st_reg.cnt_pin_sync[1];
    st_next.ext_pin_sync = {st_reg.ext_pin_sync[0], ext_capture_reload_pin};
    st_next.ext_pin_prev = st_reg.ext_pin_sync[1];
    cnt_edge = fell(st_reg.cnt_pin_prev, st_reg.cnt_pin_sync[1]);
    ext_edge = fell(st_reg.ext_pin_prev, st_reg.ext_pin_sync[1]);

    // timer 2 prescaler free-runs, so the first step lands 1 to 12 clk after run is set
    // per-timer prescalers, each on its own fast select
    ps2 = prescale(st_reg.pre_t2, st_reg.rate[TTR_RATE_T2_BIT]);
    ps1 = prescale(st_reg.pre_t1, st_reg.rate[TTR_RATE_T1_BIT]);
    ps0 = prescale(st_reg.pre_t0, st_reg.rate[TTR_RATE_T0_BIT]);
    st_next.pre_t2 = ps2[4:1];
    st_next.pre_t1 = ps1[4:1];
    st_next.pre_t0 = ps0[4:1];
    st_next.tick   = {ps2[0], ps1[0], ps0[0]};

    // baud time base ignores the fast select bit
    baud_ps   = (st_reg.pre_t2[0] == TTR_BAUD_LAST[0]) ? 4'h0 : 4'h1;
    baud_tick = (st_reg.pre_t2[0] == TTR_BAUD_LAST[0]);
    if (mode == TTR_MODE_BAUD && !ct_sel)
    begin
      st_next.pre_t2 = baud_ps;
    end

    // step source: pin edges bypass every prescaler
    if (ct_sel)
    begin
      step = cnt_edge;
    end
    else if (mode == TTR_MODE_BAUD)
    begin
      step = baud_tick;
    end
    else
    begin
      step = ps2[0];
    end
    step = step && (mode != TTR_MODE_OFF) && TIMER2_PRESENT;

    rolls    = step && (st_reg.cnt == TTR_CNT_MAX);
    trig     = ext_edge && ex_en && (mode == TTR_MODE_CAPTURE || mode == TTR_MODE_RELOAD)
               && TIMER2_PRESENT;
    cnt_step = 16'(st_reg.cnt + 16'h0001);

    ovf_set = rolls && !baud;
    // in baud mode the pin edge still raises the flag, but causes no reload
    exf_set = ext_edge && ex_en && run && TIMER2_PRESENT;
    // a capture edge beats a software write to the same reload byte
    cap_now = trig && (mode == TTR_MODE_CAPTURE);

    // registered, so the overflow output is exactly one clk wide
    st_next.ovf_pulse     = rolls && !baud;
    st_next.rx_baud_pulse = rolls && st_reg.ctrl[TTR_CTL_RXB_BIT];
    st_next.tx_baud_pulse = rolls && st_reg.ctrl[TTR_CTL_TXB_BIT];

    // count update
    if (step)
    begin
      st_next.cnt = cnt_step;
    end
    // capture mode simply wraps to zero; the other modes reload
    if (rolls && mode != TTR_MODE_CAPTURE)
    begin
      st_next.cnt = st_reg.rcap;
    end
    if (trig && mode == TTR_MODE_RELOAD)
    begin
      st_next.cnt = st_reg.rcap;
    end
    if (cap_now)
    begin
      st_next.rcap = st_reg.cnt;
    end

    // register writes; a write to a count byte overrides the hardware step
    if (req.wr)
    begin
      case (req.addr)
        TTR_ADDR_RATE:
        begin
          st_next.rate = req.wdata & TTR_RATE_WMASK;
        end
        TTR_ADDR_CTRL:
        begin
          if (TIMER2_PRESENT)
          begin
            st_next.ctrl = req.wdata;
          end
        end
        TTR_ADDR_RCAP_L:
        begin
          if (TIMER2_PRESENT && !cap_now)
          begin
            st_next.rcap[7:0] = req.wdata;
          end
        end
        TTR_ADDR_RCAP_H:
        begin
          if (TIMER2_PRESENT && !cap_now)
          begin
            st_next.rcap[15:8] = req.wdata;
          end
        end
        // byte writes are not paired; software must avoid tearing across a carry
        TTR_ADDR_CNT_L:
        begin
          if (TIMER2_PRESENT)
          begin
            st_next.cnt[7:0] = req.wdata;
          end
        end
        TTR_ADDR_CNT_H:
        begin
          if (TIMER2_PRESENT)
          begin
            st_next.cnt[15:8] = req.wdata;
          end
        end
        default:
        begin
        end
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    if (ovf_set)
    begin
      st_next.ctrl[TTR_CTL_OVF_BIT] = 1'b1;
    end
    if (exf_set)
    begin
      st_next.ctrl[TTR_CTL_EXF_BIT] = 1'b1;
    end

    // flags request the interrupt whether set by hardware or written by software
    st_next.irq = 1'b0;
    if (timer2_irq_enable)
    begin
      st_next.irq = st_next.ctrl[TTR_CTL_OVF_BIT] || st_next.ctrl[TTR_CTL_EXF_BIT];
    end

    // read data registered one cycle after the strobe, zero otherwise
    st_next.rdata = 8'h00;
    if (req.rd)
    begin
      st_next.rdata = read_mux(req.addr, st_reg);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg      <= '0;
      st_reg.rate <= TTR_RATE_RST;
      st_reg.ctrl <= TTR_CTL_RST;
      st_reg.rcap <= TTR_WORD_RST;
      st_reg.cnt  <= TTR_WORD_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sfr_rdata          = st_reg.rdata;
  assign overflow_pulse_out = st_reg.ovf_pulse;
  assign rx_baud_clk_pulse  = st_reg.rx_baud_pulse;
  assign tx_baud_clk_pulse  = st_reg.tx_baud_pulse;
  assign timer2_irq         = st_reg.irq;
  assign timer1_tick        = st_reg.tick[1];
  assign timer0_tick        = st_reg.tick[0];

endmodule

// ==== tb/ttr_timer_two_asserts.sv ====
`timescale 1ns/1ps
module ttr_timer_two_asserts (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer2_irq_enable,
  input wire logic       overflow_pulse_out,
  input wire logic       rx_baud_clk_pulse,
  input wire logic       tx_baud_clk_pulse,
  input wire logic       timer2_irq,
  input wire logic       timer1_tick,
  input wire logic       timer0_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle_zero: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data not zero while idle");
  a_ovf_one_cycle: assert property (overflow_pulse_out |=> !overflow_pulse_out)
    else $error("overflow pulse longer than one cycle");
  a_baud_no_ovf: assert property (rx_baud_clk_pulse |-> !overflow_pulse_out)
    else $error("overflow pulse during baud generation");
  a_tx_pulse_one: assert property (tx_baud_clk_pulse |=> !tx_baud_clk_pulse)
    else $error("transmit shift pulse too long");
  a_t1_tick_gap: assert property (timer1_tick |=> !timer1_tick [*3])
    else $error("timer one tick spacing below four");
  a_t0_tick_gap: assert property (timer0_tick |=> !timer0_tick [*3])
    else $error("timer zero tick spacing below four");
  a_irq_masked: assert property (!timer2_irq_enable |=> !timer2_irq)
    else $error("interrupt while disabled");
  a_ovf_irq: assert property (overflow_pulse_out && timer2_irq_enable |-> ##[0:1] timer2_irq)
    else $error("overflow did not request interrupt");
endmodule

// ==== tb/ttr_pin_partner.sv ====
`timescale 1ns/1ps
module ttr_pin_partner (
  input  wire logic sys_clk,
  output logic      count_input_pin,
  output logic      ext_capture_reload_pin
);
  // both pins idle high; held at least three edges so the two-flop sampler sees each level
  initial
  begin
    count_input_pin = 1'b1;
    ext_capture_reload_pin = 1'b1;
  end
  task automatic fall_ext();
    ext_capture_reload_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 ext_capture_reload_pin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse_count(input int k);
    repeat (k)
    begin
      count_input_pin = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 count_input_pin = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
    end
  endtask
endmodule

// ==== tb/ttr_timer_two_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module ttr_timer_two_tb_top;
  import ttr_pkg::*;
  logic        sys_clk, rstn, sfr_wr, sfr_rd, timer2_irq_enable;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
  logic        count_input_pin, ext_capture_reload_pin, overflow_pulse_out, timer2_irq;
  logic        rx_baud_clk_pulse, tx_baud_clk_pulse, timer1_tick, timer0_tick;
  logic [31:0] seed;
  logic [15:0] v, r;
  logic [7:0]  adr [7];
  int          errors, compares, n;

  ttr_timer_two ttr_timer_two_inst (.sys_clk(sys_clk), .rstn(rstn), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .count_input_pin(count_input_pin), .ext_capture_reload_pin(ext_capture_reload_pin),
    .timer2_irq_enable(timer2_irq_enable), .overflow_pulse_out(overflow_pulse_out),
    .rx_baud_clk_pulse(rx_baud_clk_pulse), .tx_baud_clk_pulse(tx_baud_clk_pulse),
    .timer2_irq(timer2_irq), .timer1_tick(timer1_tick), .timer0_tick(timer0_tick));
  ttr_pin_partner ttr_pin_partner_inst (.sys_clk(sys_clk), .count_input_pin(count_input_pin),
    .ext_capture_reload_pin(ext_capture_reload_pin));

  task stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    sfr_rd = 1'b1;
    sfr_addr = a;
    @(posedge sys_clk);
    #1 sfr_rd = 1'b0;
    `CHK(nm, e, sfr_rdata)
    @(posedge sys_clk);
    #1;
  endtask
  function logic pick(int s);
    case (s)
      0: return timer1_tick;
      1: return timer0_tick;
      2: return rx_baud_clk_pulse;
      default: return overflow_pulse_out;
    endcase
  endfunction
  task wait_for(input int s);
    repeat (400)
    begin
      @(posedge sys_clk);
      #1;
      if (pick(s) === 1'b1)
        return;
    end
    errors++;
    stop_test();
  endtask
  task gap(input int s, output int g);
    wait_for(s);
    g = 0;
    do
    begin
      @(posedge sys_clk);
      #1 g++;
    end while (pick(s) !== 1'b1 && g < 400);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errors++;
    stop_test();
  end
  initial
  begin
    errors = 0;
    compares = 0;
    seed = 32'd90959;
    {rstn, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    timer2_irq_enable = 1'b1;
    adr = '{TTR_ADDR_RATE, TTR_ADDR_CTRL, TTR_ADDR_RCAP_L, TTR_ADDR_RCAP_H,
            TTR_ADDR_CNT_L, TTR_ADDR_CNT_H, 8'h90};
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
    foreach (adr[i]) rd(adr[i], 8'h00, "reset");
    wr(TTR_ADDR_RATE, 8'hff);
    rd(TTR_ADDR_RATE, TTR_RATE_WMASK, "rate");
    wr(TTR_ADDR_RATE, 8'h10);
    gap(0, n);
    `CHK("t1 gap", 4, n)
    gap(1, n);
    `CHK("t0 gap", 12, n)
    // auto-reload: low reload byte kept small so no second rollover during the reads
    wr(TTR_ADDR_RATE, 8'h20);
    r = 16'(xs()) & 16'hff7f;
    wr(TTR_ADDR_RCAP_L, r[7:0]);
    wr(TTR_ADDR_RCAP_H, r[15:8]);
    wr(TTR_ADDR_CNT_L, 8'hfe);
    wr(TTR_ADDR_CNT_H, 8'hff);
    wr(TTR_ADDR_CTRL, 8'h04);
    wait_for(3);
    rd(TTR_ADDR_CNT_H, r[15:8], "reload");
    rd(TTR_ADDR_CTRL, 8'h84, "ovf flag");
    `CHK("irq", 1'b1, timer2_irq)
    wr(TTR_ADDR_CTRL, 8'h00);
    wr(TTR_ADDR_CNT_L, 8'h10);
    rd(TTR_ADDR_CNT_L, 8'h10, "stopped");
    repeat (30) @(posedge sys_clk);
    #1 rd(TTR_ADDR_CNT_L, 8'h10, "run off");
    `CHK("irq clr", 1'b0, timer2_irq)
    wr(TTR_ADDR_CTRL, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("sw irq", 1'b1, timer2_irq)
    timer2_irq_enable = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("masked", 1'b0, timer2_irq)
    timer2_irq_enable = 1'b1;
    // capture in counter function: the count holds while the count pin idles
    v = 16'(xs()) & 16'hff7f;
    wr(TTR_ADDR_CNT_L, v[7:0]);
    wr(TTR_ADDR_CNT_H, v[15:8]);
    wr(TTR_ADDR_CTRL, 8'h0f);
    ttr_pin_partner_inst.fall_ext();
    rd(TTR_ADDR_RCAP_L, v[7:0], "cap lo");
    rd(TTR_ADDR_RCAP_H, v[15:8], "cap hi");
    rd(TTR_ADDR_CTRL, 8'h4f, "ext flag");
    ttr_pin_partner_inst.pulse_count(3);
    rd(TTR_ADDR_CNT_L, 8'(v[7:0] + 8'h03), "counted");
    wr(TTR_ADDR_CTRL, 8'h07);
    ttr_pin_partner_inst.fall_ext();
    rd(TTR_ADDR_RCAP_L, v[7:0], "no cap");
    rd(TTR_ADDR_CTRL, 8'h07, "no flag");
    // baud generator with capture select set: it must still reload every eight cycles
    wr(TTR_ADDR_RCAP_L, 8'hfc);
    wr(TTR_ADDR_RCAP_H, 8'hff);
    wr(TTR_ADDR_CNT_L, 8'hfe);
    wr(TTR_ADDR_CNT_H, 8'hff);
    wr(TTR_ADDR_CTRL, 8'h35);
    gap(2, n);
    `CHK("baud gap", 8, n)
    `CHK("tx pulse", 1'b1, tx_baud_clk_pulse)
    rd(TTR_ADDR_CTRL, 8'h35, "no ovf");
    wr(TTR_ADDR_CTRL, 8'h3d);
    ttr_pin_partner_inst.fall_ext();
    rd(TTR_ADDR_CTRL, 8'h7d, "baud ext");
    // forced reload: counter function with an idle count pin, so only the edge moves it
    wr(TTR_ADDR_CNT_H, 8'h12);
    wr(TTR_ADDR_CTRL, 8'h0e);
    ttr_pin_partner_inst.fall_ext();
    rd(TTR_ADDR_CNT_H, 8'hff, "forced hi");
    rd(TTR_ADDR_CNT_L, 8'hfc, "forced lo");
    rd(TTR_ADDR_CTRL, 8'h4e, "reload flag");
    stop_test();
  end
endmodule

bind ttr_timer_two ttr_timer_two_asserts ttr_timer_two_asserts_inst (.sys_clk(sys_clk),
  .rstn(rstn), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .timer2_irq_enable(timer2_irq_enable),
  .overflow_pulse_out(overflow_pulse_out), .rx_baud_clk_pulse(rx_baud_clk_pulse),
  .tx_baud_clk_pulse(tx_baud_clk_pulse), .timer2_irq(timer2_irq),
  .timer1_tick(timer1_tick), .timer0_tick(timer0_tick));
